// ---- common/dtc_consts.svh ----
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH

// Register indices; the control offsets are not multiples of four, so byte address = 4 * index.
`define DTC_IDX_CTRL0 8'h0e
`define DTC_IDX_CTRL1 8'h11
`define DTC_IDX_LOW0 8'h0c
`define DTC_IDX_HIGH0 8'h0d
`define DTC_IDX_LOW1 8'h0f
`define DTC_IDX_HIGH1 8'h10
`define DTC_IDX_INTC 8'h0b
`define DTC_IDX_STAT 8'h20
`define DTC_IDX_MASK 8'h21

// Control register fields.
`define DTC_MODE_HI 7
`define DTC_MODE_LO 6
`define DTC_RUN_BIT 4
`define DTC_EDGE_BIT 3
`define DTC_CTRL_RST 8'h08
`define DTC_CTRL_WMASK 8'hd8

// Interrupt control fields.
`define DTC_F0_BIT 5
`define DTC_F1_BIT 6
`define DTC_EN0_BIT 2
`define DTC_EN1_BIT 3

// Timing.
`define DTC_CLK_MHZ 100
`define DTC_INT_DIV 4

`endif

// ---- common/dtc_pkg.sv ----
package dtc_pkg;
  typedef enum logic [1:0] {
    DTC_MODE_NONE = 2'b00,
    DTC_MODE_EVENT = 2'b01,
    DTC_MODE_TIMER = 2'b10,
    DTC_MODE_PULSE = 2'b11
  } dtc_mode_t;

  typedef enum logic [1:0] {
    DTC_PW_WAIT = 2'b00,
    DTC_PW_MEAS = 2'b01,
    DTC_PW_DONE = 2'b10
  } dtc_pw_t;
endpackage

// ---- verilog/dtc_timer.sv ----
`timescale 1ns/1ps
`include "dtc_consts.svh"

// Behaviour
// - Two independent 16-bit up-counters, clocked from a pin or internally.
// - Internal count clock is the system clock divided by four.
// - Low byte writes go to a buffer, moved with the high byte write.
// - Reading the low byte register returns the holding buffer.
// - Control bits 7:6 select mode: 01 event, 10 timer, 11 pulse width.
// - Event and timer modes count up, reload preload on overflow, set flag.
// - Counter 0 overflow sets bit 5, counter 1 sets bit 6 of interrupt control.
// - Event mode: edge select 1 counts falling edges, 0 rising edges.
// - Pulse mode: edge select 1 times high pulse, 0 times low pulse.
// - Pulse end stops counting, clears run bit, keeps result until rerun.
// - Pulse mode overflow reloads and requests interrupt like other modes.
// - Run bit 4 enables counting; only software clears it outside pulse mode.
// - A counter overflow is a wake-up source for the halted processor.
// - Clearing a counter's interrupt enable blocks its interrupt in any mode.
// - Control bits 0 to 2 and 5 read as zero.
// - Stopped counter loads with preload write; running counter updates preload only.
// - Count clock is blocked while software reads the counter.
module dtc_timer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] counterInputPin,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic wakeUp
);
  import dtc_pkg::*;

  // ----------------------------------------
  // Reset synchroniser and internal divider
  // ----------------------------------------
  logic rstMeta_r;
  logic rstSync_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end
  wire rstN = rstSync_r;

  logic [1:0] divCnt_r;
  logic tick_r;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      divCnt_r <= 2'h0;
      tick_r <= 1'b0;
    end else begin
      divCnt_r <= divCnt_r + 2'h1;
      tick_r <= (divCnt_r == 2'(`DTC_INT_DIV - 1));
    end
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic awHeld_r;
  logic wHeld_r;
  logic [7:0] awIdx_r;
  logic [7:0] wByte_r;
  logic wLane_r;
  wire wrDo = awHeld_r && wHeld_r && !s_axi_bvalid;
  wire wrEn = wrDo && wLane_r;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awIdx_r <= 8'h00;
      wByte_r <= 8'h00;
      wLane_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awIdx_r <= s_axi_awaddr[9:2];
      end else if (wrDo) begin
        awHeld_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wByte_r <= s_axi_wdata[7:0];
        wLane_r <= s_axi_wstrb[0];
      end else if (wrDo) begin
        wHeld_r <= 1'b0;
      end
    end
  end
  wire wrMapped = (awIdx_r == `DTC_IDX_CTRL0) || (awIdx_r == `DTC_IDX_CTRL1) ||
                  (awIdx_r == `DTC_IDX_LOW0) || (awIdx_r == `DTC_IDX_LOW1) ||
                  (awIdx_r == `DTC_IDX_HIGH0) || (awIdx_r == `DTC_IDX_HIGH1) ||
                  (awIdx_r == `DTC_IDX_INTC) || (awIdx_r == `DTC_IDX_STAT) ||
                  (awIdx_r == `DTC_IDX_MASK);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= !awHeld_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !wHeld_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (wrDo) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read: address accepted, then data presented one cycle later.
  logic rdPend_r;
  logic [7:0] arIdx_r;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s_axi_arready <= 1'b0;
      rdPend_r <= 1'b0;
      arIdx_r <= 8'h00;
    end else begin
      s_axi_arready <= !rdPend_r && !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        rdPend_r <= 1'b1;
        arIdx_r <= s_axi_araddr[9:2];
      end else begin
        rdPend_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  logic [7:0] ctrl_r [2];
  logic [7:0] lowBuf_r [2];
  logic [15:0] preload_r [2];
  logic [15:0] count_r [2];
  logic [1:0] pin_r;
  logic [1:0] ovf;
  dtc_pw_t pw_r [2];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gCh
      wire [7:0] idxCtrl = (g == 0) ? `DTC_IDX_CTRL0 : `DTC_IDX_CTRL1;
      wire [7:0] idxLow = (g == 0) ? `DTC_IDX_LOW0 : `DTC_IDX_LOW1;
      wire [7:0] idxHigh = (g == 0) ? `DTC_IDX_HIGH0 : `DTC_IDX_HIGH1;
      dtc_mode_t mode;
      assign mode = dtc_mode_t'(ctrl_r[g][`DTC_MODE_HI:`DTC_MODE_LO]);
      wire run = ctrl_r[g][`DTC_RUN_BIT];
      wire edgeSel = ctrl_r[g][`DTC_EDGE_BIT];
      wire rise = counterInputPin[g] && !pin_r[g];
      wire fall = !counterInputPin[g] && pin_r[g];
      // A pending read of this channel's counter freezes it for a consistent snapshot.
      wire rdBlock = (s_axi_arvalid && s_axi_arready &&
                      (s_axi_araddr[9:2] == idxHigh || s_axi_araddr[9:2] == idxLow)) ||
                     (rdPend_r && (arIdx_r == idxHigh || arIdx_r == idxLow));
      wire evtEdge = edgeSel ? fall : rise;
      wire startEdge = edgeSel ? rise : fall;
      wire stopEdge = edgeSel ? fall : rise;
      wire inc = run && !rdBlock &&
                 ((mode == DTC_MODE_EVENT && evtEdge) ||
                  (mode == DTC_MODE_TIMER && tick_r) ||
                  (mode == DTC_MODE_PULSE && pw_r[g] == DTC_PW_MEAS && tick_r));
      wire pwStop = run && mode == DTC_MODE_PULSE && pw_r[g] == DTC_PW_MEAS && stopEdge;
      wire ctrlWr = wrEn && awIdx_r == idxCtrl;
      assign ovf[g] = inc && (count_r[g] == 16'hffff);

      always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
          ctrl_r[g] <= `DTC_CTRL_RST;
        end else if (ctrlWr) begin
          ctrl_r[g] <= wByte_r & `DTC_CTRL_WMASK;
        end else if (pwStop) begin
          ctrl_r[g][`DTC_RUN_BIT] <= 1'b0;
        end
      end

      always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
          pw_r[g] <= DTC_PW_WAIT;
        end else if (ctrlWr || mode != DTC_MODE_PULSE || !run) begin
          pw_r[g] <= DTC_PW_WAIT;
        end else begin
          case (pw_r[g])
            DTC_PW_WAIT: if (startEdge) begin
              pw_r[g] <= DTC_PW_MEAS;
            end
            DTC_PW_MEAS: if (stopEdge) begin
              pw_r[g] <= DTC_PW_DONE;
            end
            DTC_PW_DONE: pw_r[g] <= DTC_PW_DONE;
            default: pw_r[g] <= DTC_PW_WAIT;
          endcase
        end
      end

      always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
          lowBuf_r[g] <= 8'h00;
          preload_r[g] <= 16'h0000;
          count_r[g] <= 16'h0000;
        end else begin
          if (wrEn && awIdx_r == idxLow) begin
            lowBuf_r[g] <= wByte_r;
          end
          if (wrEn && awIdx_r == idxHigh) begin
            preload_r[g] <= {wByte_r, lowBuf_r[g]};
          end
          if (wrEn && awIdx_r == idxHigh && !run) begin
            count_r[g] <= {wByte_r, lowBuf_r[g]};
          end else if (ovf[g]) begin
            count_r[g] <= preload_r[g];
          end else if (inc) begin
            count_r[g] <= count_r[g] + 16'h0001;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pin_r <= 2'b00;
    end else begin
      pin_r <= counterInputPin;
    end
  end

  // ----------------------------------------
  // Flags, enables, interrupt and wake-up
  // ----------------------------------------
  logic [1:0] flag_r;
  logic [1:0] irqEn_r;
  logic [1:0] mask_r;
  wire intcWr = wrEn && awIdx_r == `DTC_IDX_INTC;
  wire statWr = wrEn && awIdx_r == `DTC_IDX_STAT;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      flag_r <= 2'b00;
      irqEn_r <= 2'b00;
      mask_r <= 2'b00;
    end else begin
      // A new overflow wins over a clear in the same cycle.
      flag_r[0] <= ovf[0] | (flag_r[0] &
                   !(intcWr & !wByte_r[`DTC_F0_BIT]) & !(statWr & wByte_r[0]));
      flag_r[1] <= ovf[1] | (flag_r[1] &
                   !(intcWr & !wByte_r[`DTC_F1_BIT]) & !(statWr & wByte_r[1]));
      if (intcWr) begin
        irqEn_r <= {wByte_r[`DTC_EN1_BIT], wByte_r[`DTC_EN0_BIT]};
      end
      if (wrEn && awIdx_r == `DTC_IDX_MASK) begin
        mask_r <= wByte_r[1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      irq <= 1'b0;
      wakeUp <= 1'b0;
    end else begin
      irq <= |(flag_r & irqEn_r & mask_r);
      wakeUp <= |ovf;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (rdPend_r) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      case (arIdx_r)
        `DTC_IDX_CTRL0: s_axi_rdata <= {24'h0, ctrl_r[0]};
        `DTC_IDX_CTRL1: s_axi_rdata <= {24'h0, ctrl_r[1]};
        `DTC_IDX_LOW0: s_axi_rdata <= {24'h0, lowBuf_r[0]};
        `DTC_IDX_LOW1: s_axi_rdata <= {24'h0, lowBuf_r[1]};
        `DTC_IDX_HIGH0: s_axi_rdata <= {24'h0, count_r[0][15:8]};
        `DTC_IDX_HIGH1: s_axi_rdata <= {24'h0, count_r[1][15:8]};
        `DTC_IDX_INTC: s_axi_rdata <= {25'h0, flag_r, 1'b0, irqEn_r, 2'b00};
        `DTC_IDX_STAT: s_axi_rdata <= {30'h0, flag_r};
        `DTC_IDX_MASK: s_axi_rdata <= {30'h0, mask_r};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_DIV4: assert property (@(posedge clk) disable iff (!rstN)
    tick_r |=> !tick_r [*3] ##1 tick_r) else $error("divider not by four");
  AST_RESERVED: assert property (@(posedge clk) disable iff (!rstN)
    (ctrl_r[0] & 8'h27) == 8'h00 && (ctrl_r[1] & 8'h27) == 8'h00)
    else $error("reserved control bits set");
  AST_RELOAD: assert property (@(posedge clk) disable iff (!rstN)
    ovf[0] && !(wrEn && awIdx_r == `DTC_IDX_HIGH0) |=> count_r[0] == $past(preload_r[0]))
    else $error("overflow did not reload");
  AST_FLAG: assert property (@(posedge clk) disable iff (!rstN)
    ovf[1] |=> flag_r[1]) else $error("overflow flag not set");
  AST_STICKY: assert property (@(posedge clk) disable iff (!rstN)
    flag_r[0] && !wrEn |=> flag_r[0]) else $error("flag lost without clear");
  AST_IRQ: assert property (@(posedge clk) disable iff (!rstN)
    !irqEn_r[0] && !irqEn_r[1] |=> !irq) else $error("irq while disabled");
  AST_WAKE: assert property (@(posedge clk) disable iff (!rstN)
    ovf[0] |=> wakeUp) else $error("no wake-up on overflow");
  AST_STOPPED: assert property (@(posedge clk) disable iff (!rstN)
    !ctrl_r[0][`DTC_RUN_BIT] && !(wrEn && awIdx_r == `DTC_IDX_HIGH0)
    |=> count_r[0] == $past(count_r[0])) else $error("stopped counter moved");
  AST_LOWBUF: assert property (@(posedge clk) disable iff (!rstN)
    wrEn && awIdx_r == `DTC_IDX_LOW0 && ctrl_r[0][`DTC_RUN_BIT] |=> preload_r[0] == $past(preload_r[0]))
    else $error("low write reached preload");
endmodule

// ---- tb/dtc_pin_model.sv ----
`timescale 1ns/1ps

// -----------------------------------------------------------------
// External pin source for both counters
// -----------------------------------------------------------------
module dtc_pin_model (
  input wire logic clk,
  output logic [1:0] pin
);
  initial pin = 2'b00;

  // Levels change just after a rising edge and are held long enough
  // for the synchronous edge detector to see each level at least once.
  task automatic drive(input int ch, input logic lvl, input int hold);
    @(posedge clk);
    pin[ch] <= lvl;
    repeat (hold) @(posedge clk);
  endtask
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`include "dtc_consts.svh"

module testbench;
  logic clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq, wakeUp;
  logic wakeSeen = 1'b0;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic [1:0] bresp, rresp, r, pin, wr;
  logic [3:0] wstrb;
  logic [15:0] v;
  int error_cnt, num_checks, seed, n;

  dtc_pin_model dtc_pin_model_inst (.clk(clk), .pin(pin));
  dtc_timer dtc_timer_inst (.clk(clk), .nrst(nrst), .counterInputPin(pin),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq), .wakeUp(wakeUp));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) if (wakeUp === 1'b1) wakeSeen <= 1'b1;

  // -----------------------------------------------------------------
  // Comparison, bus tasks and verdict
  // -----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axw(input logic [7:0] idx, input logic [7:0] dat);
    awaddr <= {22'h0, idx, 2'b00};
    wdata <= {24'h0, dat};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin do @(posedge clk); while (awready !== 1'b1); awvalid <= 1'b0; end
      begin do @(posedge clk); while (wready !== 1'b1); wvalid <= 1'b0; end
    join
    do @(posedge clk); while (bvalid !== 1'b1);
    wr = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic axr(input logic [7:0] idx, output logic [31:0] dat,
                     output logic [1:0] resp);
    araddr <= {22'h0, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    dat = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // A full run needs well under 40 us; the margin covers slow answers.
  initial begin
    #300us;
    error_cnt++;
    tally_and_finish();
  end

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hf;
    nrst = 1'b0;
    error_cnt = 0;
    num_checks = 0;
    seed = 96356;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    axr(`DTC_IDX_CTRL0, d, r); chk(d, 32'h08);
    axr(`DTC_IDX_CTRL1, d, r); chk(d, 32'h08);
    axw(`DTC_IDX_CTRL0, 8'h27);
    chk({30'h0, wr}, 32'h0);
    axr(`DTC_IDX_CTRL0, d, r); chk(d, 32'h00);
    axr(8'h30, d, r); chk(d, 32'h0);
    chk({30'h0, r}, 32'h2);
    axw(8'h30, 8'h00);
    chk({30'h0, wr}, 32'h2);
    // A write without its low byte lane enabled must leave the register alone.
    wstrb <= 4'h0;
    axw(`DTC_IDX_CTRL1, 8'h10);
    wstrb <= 4'hf;
    axr(`DTC_IDX_CTRL1, d, r); chk(d, 32'h08);
    // Stopped load: low goes to the buffer, high write moves both.
    v = 16'($random(seed));
    axw(`DTC_IDX_LOW0, v[7:0]);
    axr(`DTC_IDX_LOW0, d, r); chk(d, {24'h0, v[7:0]});
    axw(`DTC_IDX_HIGH0, v[15:8]);
    axr(`DTC_IDX_HIGH0, d, r); chk(d, {24'h0, v[15:8]});
    // Running: a high write only updates the preload.
    axw(`DTC_IDX_LOW0, 8'h00);
    axw(`DTC_IDX_HIGH0, 8'h01);
    axw(`DTC_IDX_CTRL0, 8'h90);
    axw(`DTC_IDX_LOW0, 8'h33);
    axr(`DTC_IDX_LOW0, d, r); chk(d, 32'h33);
    axw(`DTC_IDX_HIGH0, 8'h55);
    axr(`DTC_IDX_HIGH0, d, r); chk(d, 32'h01);
    axw(`DTC_IDX_CTRL0, 8'h00);
    // Timer overflow with enable and mask set.
    axw(`DTC_IDX_MASK, 8'h01);
    axw(`DTC_IDX_INTC, 8'h04);
    axw(`DTC_IDX_LOW0, 8'hfe);
    axw(`DTC_IDX_HIGH0, 8'hff);
    axw(`DTC_IDX_CTRL0, 8'h90);
    n = 0;
    while (irq !== 1'b1 && n < 60) begin @(posedge clk); n++; end
    chk({31'h0, irq}, 32'h1);
    axw(`DTC_IDX_CTRL0, 8'h00);
    axr(`DTC_IDX_INTC, d, r); chk({31'h0, d[`DTC_F0_BIT]}, 32'h1);
    chk({31'h0, wakeSeen}, 32'h1);
    axw(`DTC_IDX_INTC, 8'h20);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    axr(`DTC_IDX_INTC, d, r); chk({31'h0, d[`DTC_F0_BIT]}, 32'h1);
    axw(`DTC_IDX_STAT, 8'h03);
    // Event counting on pin 1, rising then falling edge select.
    for (int te = 0; te < 2; te++) begin
      n = 2 + ($random(seed) & 32'h3);
      v = 16'(32'h10000 - n);
      axw(`DTC_IDX_LOW1, v[7:0]);
      axw(`DTC_IDX_HIGH1, v[15:8]);
      axw(`DTC_IDX_STAT, 8'h03);
      axw(`DTC_IDX_CTRL1, 8'h50 | 8'(te << 3));
      repeat (n - 1) begin
        dtc_pin_model_inst.drive(1, 1'b1, 3);
        dtc_pin_model_inst.drive(1, 1'b0, 3);
      end
      dtc_pin_model_inst.drive(1, 1'b1, 3);
      axr(`DTC_IDX_STAT, d, r); chk({31'h0, d[1]}, 32'(te == 0));
      dtc_pin_model_inst.drive(1, 1'b0, 3);
      axr(`DTC_IDX_STAT, d, r); chk({31'h0, d[1]}, 32'h1);
      axw(`DTC_IDX_CTRL1, 8'h08);
    end
    // Pulse width of one high pulse on pin 0.
    axw(`DTC_IDX_LOW0, 8'h00);
    axw(`DTC_IDX_HIGH0, 8'h00);
    axw(`DTC_IDX_CTRL0, 8'hd8);
    dtc_pin_model_inst.drive(0, 1'b1, 40);
    dtc_pin_model_inst.drive(0, 1'b0, 5);
    axr(`DTC_IDX_CTRL0, d, r); chk(d, 32'hc8);
    dtc_pin_model_inst.drive(0, 1'b1, 2000);
    axr(`DTC_IDX_HIGH0, d, r); chk(d, 32'h00);
    // Pulse mode overflow: start on a falling edge, reload and flag.
    axw(`DTC_IDX_STAT, 8'h03);
    axw(`DTC_IDX_LOW0, 8'hfe);
    axw(`DTC_IDX_HIGH0, 8'hff);
    axw(`DTC_IDX_CTRL0, 8'hd0);
    dtc_pin_model_inst.drive(0, 1'b0, 20);
    dtc_pin_model_inst.drive(0, 1'b1, 5);
    axr(`DTC_IDX_STAT, d, r); chk({31'h0, d[0]}, 32'h1);
    axr(`DTC_IDX_HIGH0, d, r); chk(d, 32'hff);
    axr(`DTC_IDX_CTRL0, d, r); chk(d, 32'hc0);
    // Mode 00 counts neither pin edges nor internal ticks.
    axw(`DTC_IDX_STAT, 8'h03);
    axw(`DTC_IDX_LOW1, 8'hff);
    axw(`DTC_IDX_HIGH1, 8'hff);
    axw(`DTC_IDX_CTRL1, 8'h10);
    dtc_pin_model_inst.drive(1, 1'b1, 8);
    dtc_pin_model_inst.drive(1, 1'b0, 8);
    axr(`DTC_IDX_STAT, d, r); chk({31'h0, d[1]}, 32'h0);
    axr(`DTC_IDX_HIGH1, d, r); chk(d, 32'hff);
    tally_and_finish();
  end
endmodule
